// >>> design/jss_defs.vh
/*
  constants for the job select and self check block: register offsets,
  field positions, reset values and limits.
  assumes a 32-bit classic wishbone slave, 25 mhz clock.
*/
`ifndef JSS_DEFS_VH
`define JSS_DEFS_VH

`define JSS_CLK_MHZ        25
`define JSS_DEB_TIME_US    1000
`define JSS_DEB_CYC        (`JSS_DEB_TIME_US * `JSS_CLK_MHZ)

`define JSS_OFF_CTRL       8'h00
`define JSS_OFF_ROUTE      8'h04
`define JSS_OFF_STATUS     8'h08
`define JSS_OFF_JOB        8'h0c
`define JSS_OFF_FORCE      8'h10
`define JSS_OFF_ZERO       8'h14
`define JSS_OFF_SPAN       8'h18
`define JSS_OFF_RATED      8'h1c
`define JSS_OFF_CAL        8'h20
`define JSS_OFF_RATIO      8'h24
`define JSS_OFF_INPUTS     8'h28

`define JSS_CTRL_SCHEME    0
`define JSS_CTRL_TEST      1
`define JSS_CTRL_WIRING    2
`define JSS_CTRL_ZADJ      3

`define JSS_ROUTE_RESET    32'h00000000
`define JSS_RATED_RESET    16'h03e8
`define JSS_CAL_RESET      16'h03e8
`define JSS_RATIO_RESET    16'h0064

`define JSS_ERR_NONE       3'h0
`define JSS_ERR_PROG       3'h1
`define JSS_ERR_WORK       3'h2
`define JSS_ERR_ADC        3'h3
`define JSS_ERR_SUM        3'h4
`define JSS_ERR_ZERO       3'h5
`define JSS_ERR_SPAN       3'h6

`endif

// >>> design/jss_job_select_and_self_check.v
/*
  supervisory logic of a fastening torque controller: job select decode,
  self test sequencer, wiring test, zero adjust and torque polarity.
  assumes classic wishbone master on clk_i, contact inputs asynchronous,
  memory/converter test results and sensor samples supplied by other logic.
*/
// The register addresses and the Wishbone register port were chosen for this implementation.
// Summary of operation
// R1 - with scheme 0 the job is one plus the binary code on inputs a, b and c, jobs 1 to 8.
// R2 - with scheme 1 five single job inputs pick jobs 1 to 5 and nothing higher.
// R3 - a job input is active while its terminal is shorted to common by a contact.
// R4 - each job function is routed by configuration to any of the five input terminals.
// R5 - self test checks program memory, working memory, converter, then settings sum.
// R6 - a zero error is flagged when no-load offset is outside minus to plus six percent.
// R7 - a span error is flagged when simulated rated load reads outside 94 to 106 percent.
// R8 - in wiring test the state of every input terminal is shown continuously.
// R9 - each operator selection of an output in wiring test inverts its forced state.
// R10 - forceable outputs are five terminal outputs, pass lamp, fail lamp and valve.
// R11 - a zero adjust command stores the present offset as correction, busy until done.
// R12 - span value is the calibration value times the ratio divided by 100; zero shown as magnitude.
// R13 - switches 1,3 on and 2,4 off keep polarity, the opposite pattern inverts the sign.
// R14 - in scheme 1 several active job inputs select the lowest numbered job.
// R15 - each contact input is debounced over several samples before use.
`include "jss_defs.vh"

module jss_job_select_and_self_check (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire [31:0] wb_adr_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  input  wire [3:0]  wb_sel_i,
  input  wire        wb_we_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  output reg         wb_ack_o,
  output wire        wb_err_o,
  input  wire [4:0]  term_in_n_i,
  input  wire [3:0]  polarity_switch_bank_i,
  input  wire        prog_mem_ok_i,
  input  wire        work_mem_ok_i,
  input  wire        adc_ok_i,
  input  wire        settings_sum_ok_i,
  input  wire [15:0] sensor_sample_i,
  input  wire [4:0]  norm_out_i,
  input  wire        norm_pass_lamp_i,
  input  wire        norm_fail_lamp_i,
  input  wire        norm_valve_i,
  output reg  [4:0]  term_out_o,
  output reg         tool_pass_lamp_o,
  output reg         tool_fail_lamp_o,
  output reg         valve_o,
  output reg         span_stim_o,
  output reg  [15:0] torque_o,
  output reg  [3:0]  job_number_o
);

  localparam ST_IDLE  = 3'd0;
  localparam ST_PROG  = 3'd1;
  localparam ST_WORK  = 3'd2;
  localparam ST_ADC   = 3'd3;
  localparam ST_SUM   = 3'd4;
  localparam ST_ZERO  = 3'd5;
  localparam ST_SPAN  = 3'd6;
  localparam ST_ZADJ  = 3'd7;

  localparam integer DEB_CYC_INT = `JSS_DEB_CYC;
  localparam [15:0]  DEB_CYC     = DEB_CYC_INT[15:0];

  // percent of rated value, limit as fraction of rated
  function [31:0] pct;
    input [15:0] rated;
    input [7:0]  p;
    begin
      pct = (rated * p) / 32'd100;
    end
  endfunction

  function [15:0] mag;
    input [15:0] v;
    begin
      mag = v[15] ? (~v + 16'h0001) : v;
    end
  endfunction

  // input synchroniser and debounce
  reg [4:0]  sync1_reg;
  reg [4:0]  sync2_reg;
  reg [4:0]  deb_reg;
  reg [15:0] deb_cnt_reg [0:4];
  integer    i;

  always @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
    end else begin
      sync1_reg <= ~term_in_n_i; // R3
      sync2_reg <= sync1_reg;
    end
  end

  always @(posedge clk_i) begin
    for (i = 0; i < 5; i = i + 1) begin
      if (rst_i) begin
        deb_reg[i]     <= 1'b0;
        deb_cnt_reg[i] <= 16'h0000;
      end else if (sync2_reg[i] == deb_reg[i]) begin
        deb_cnt_reg[i] <= 16'h0000;
      end else if (deb_cnt_reg[i] == DEB_CYC - 16'h0001) begin
        deb_reg[i]     <= sync2_reg[i]; // R15
        deb_cnt_reg[i] <= 16'h0000;
      end else begin
        deb_cnt_reg[i] <= deb_cnt_reg[i] + 16'h0001;
      end
    end
  end

  // switch bank synchroniser, the switches are not on clk_i
  reg [3:0]  pol_sync1_reg;
  reg [3:0]  pol_sync2_reg;

  always @(posedge clk_i) begin
    if (rst_i) begin
      pol_sync1_reg <= 4'h0;
      pol_sync2_reg <= 4'h0;
    end else begin
      pol_sync1_reg <= polarity_switch_bank_i;
      pol_sync2_reg <= pol_sync1_reg;
    end
  end

  // registers
  reg        scheme_reg;
  reg        wiring_reg;
  reg [31:0] route_reg;
  reg [7:0]  force_reg;
  reg [15:0] zero_reg;
  reg [15:0] rated_reg;
  reg [15:0] cal_reg;
  reg [15:0] ratio_reg;
  reg [2:0]  state_reg;
  reg [2:0]  err_reg;
  reg        pass_reg;
  reg        done_reg;
  reg [31:0] span_reg;

  // routing: one 3-bit terminal index per job function, five functions
  function func_in;
    input [31:0] route;
    input [4:0]  ins;
    input [2:0]  f;
    reg   [2:0]  t;
    begin
      t = route[f*3 +: 3];
      func_in = (t < 3'd5) ? ins[t] : 1'b0;
    end
  endfunction

  reg [4:0] fn;
  reg [3:0] job_next;
  always @* begin
    fn[0] = func_in(route_reg, deb_reg, 3'd0); // R4
    fn[1] = func_in(route_reg, deb_reg, 3'd1);
    fn[2] = func_in(route_reg, deb_reg, 3'd2);
    fn[3] = func_in(route_reg, deb_reg, 3'd3);
    fn[4] = func_in(route_reg, deb_reg, 3'd4);
    if (!scheme_reg) begin
      job_next = {1'b0, fn[2], fn[1], fn[0]} + 4'd1; // R1
    end else if (fn[0]) begin
      job_next = 4'd1; // R14
    end else if (fn[1]) begin
      job_next = 4'd2;
    end else if (fn[2]) begin
      job_next = 4'd3;
    end else if (fn[3]) begin
      job_next = 4'd4;
    end else if (fn[4]) begin
      job_next = 4'd5; // R2
    end else begin
      job_next = 4'd1;
    end
  end

  wire       acc   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       wr    = acc & wb_we_i & wb_sel_i[0];
  wire [7:0] adr   = wb_adr_i[7:0];
  wire       hit   = (wb_adr_i[31:6] == 26'h0) && (adr[1:0] == 2'b00) && (adr <= `JSS_OFF_INPUTS);
  wire       start = wr && adr == `JSS_OFF_CTRL && wb_dat_i[`JSS_CTRL_TEST];
  wire       zcmd  = wr && adr == `JSS_OFF_CTRL && wb_dat_i[`JSS_CTRL_ZADJ];
  wire       busy  = state_reg != ST_IDLE;
  wire       inv   = ~pol_sync2_reg[0] & pol_sync2_reg[1] &
                     ~pol_sync2_reg[2] & pol_sync2_reg[3];
  wire [15:0] corr = sensor_sample_i - zero_reg;
  wire [15:0] amag = mag(sensor_sample_i);

  assign wb_err_o = 1'b0;

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o   <= 1'b0;
      scheme_reg <= 1'b0;
      wiring_reg <= 1'b0;
      route_reg  <= `JSS_ROUTE_RESET;
      force_reg  <= 8'h00;
      rated_reg  <= `JSS_RATED_RESET;
      cal_reg    <= `JSS_CAL_RESET;
      ratio_reg  <= `JSS_RATIO_RESET;
    end else begin
      wb_ack_o <= acc;
      if (wr && adr == `JSS_OFF_CTRL) begin
        scheme_reg <= wb_dat_i[`JSS_CTRL_SCHEME];
        wiring_reg <= wb_dat_i[`JSS_CTRL_WIRING];
      end
      if (wr && adr == `JSS_OFF_ROUTE) route_reg <= {17'h0, wb_dat_i[14:0]};
      if (wr && adr == `JSS_OFF_FORCE) force_reg <= force_reg ^ wb_dat_i[7:0]; // R9
      if (wr && adr == `JSS_OFF_RATED) rated_reg <= wb_dat_i[15:0];
      if (wr && adr == `JSS_OFF_CAL)   cal_reg   <= wb_dat_i[15:0];
      if (wr && adr == `JSS_OFF_RATIO) ratio_reg <= wb_dat_i[15:0];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (acc && !wb_we_i && hit) begin
      if (adr == `JSS_OFF_CTRL) wb_dat_o <= {30'h0, wiring_reg, scheme_reg};
      else if (adr == `JSS_OFF_ROUTE) wb_dat_o <= route_reg;
      else if (adr == `JSS_OFF_STATUS)
        wb_dat_o <= {24'h0, busy, done_reg, pass_reg, inv, 1'b0, err_reg};
      else if (adr == `JSS_OFF_JOB) wb_dat_o <= {28'h0, job_number_o};
      else if (adr == `JSS_OFF_FORCE) wb_dat_o <= {24'h0, force_reg};
      else if (adr == `JSS_OFF_ZERO) wb_dat_o <= {16'h0, mag(zero_reg)}; // R12
      else if (adr == `JSS_OFF_SPAN) wb_dat_o <= span_reg;
      else if (adr == `JSS_OFF_RATED) wb_dat_o <= {16'h0, rated_reg};
      else if (adr == `JSS_OFF_CAL) wb_dat_o <= {16'h0, cal_reg};
      else if (adr == `JSS_OFF_RATIO) wb_dat_o <= {16'h0, ratio_reg};
      else wb_dat_o <= {27'h0, deb_reg}; // R8
    end else if (acc) begin
      wb_dat_o <= 32'h0;
    end
  end

  // self test and zero adjust sequencer
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg   <= ST_IDLE;
      err_reg     <= `JSS_ERR_NONE;
      pass_reg    <= 1'b0;
      done_reg    <= 1'b0;
      zero_reg    <= 16'h0000;
      span_stim_o <= 1'b0;
      span_reg    <= 32'h0;
    end else begin
      span_reg <= (cal_reg * ratio_reg) / 32'd100; // R12
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            state_reg <= ST_PROG;
            err_reg   <= `JSS_ERR_NONE;
            pass_reg  <= 1'b0;
            done_reg  <= 1'b0;
          end else if (zcmd) begin
            state_reg <= ST_ZADJ; // R11
          end
        end
        ST_PROG: begin
          if (!prog_mem_ok_i) begin
            err_reg <= `JSS_ERR_PROG;
            state_reg <= ST_IDLE;
            done_reg <= 1'b1;
          end else state_reg <= ST_WORK; // R5
        end
        ST_WORK: begin
          if (!work_mem_ok_i) begin
            err_reg <= `JSS_ERR_WORK;
            state_reg <= ST_IDLE;
            done_reg <= 1'b1;
          end else state_reg <= ST_ADC;
        end
        ST_ADC: begin
          if (!adc_ok_i) begin
            err_reg <= `JSS_ERR_ADC;
            state_reg <= ST_IDLE;
            done_reg <= 1'b1;
          end else state_reg <= ST_SUM;
        end
        ST_SUM: begin
          if (!settings_sum_ok_i) begin
            err_reg <= `JSS_ERR_SUM;
            state_reg <= ST_IDLE;
            done_reg <= 1'b1;
          end else state_reg <= ST_ZERO;
        end
        ST_ZERO: begin
          if ({16'h0, amag} > pct(rated_reg, 8'd6)) begin
            err_reg <= `JSS_ERR_ZERO; // R6
            state_reg <= ST_IDLE;
            done_reg <= 1'b1;
          end else begin
            span_stim_o <= 1'b1;
            state_reg <= ST_SPAN;
          end
        end
        ST_SPAN: begin
          if (span_stim_o) begin
            span_stim_o <= 1'b0;
            state_reg <= ST_IDLE;
            done_reg <= 1'b1;
            if ({16'h0, corr} < pct(rated_reg, 8'd94) ||
                {16'h0, corr} > pct(rated_reg, 8'd106)) begin
              err_reg <= `JSS_ERR_SPAN; // R7
            end else pass_reg <= 1'b1;
          end
        end
        default: begin
          zero_reg <= sensor_sample_i; // R11
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      term_out_o       <= 5'h00;
      tool_pass_lamp_o <= 1'b0;
      tool_fail_lamp_o <= 1'b0;
      valve_o          <= 1'b0;
      torque_o         <= 16'h0000;
      job_number_o     <= 4'd1;
    end else begin
      job_number_o <= job_next;
      torque_o <= inv ? (16'h0000 - corr) : corr; // R13
      if (wiring_reg) begin
        term_out_o       <= force_reg[4:0]; // R10
        tool_pass_lamp_o <= force_reg[5];
        tool_fail_lamp_o <= force_reg[6];
        valve_o          <= force_reg[7];
      end else begin
        term_out_o       <= norm_out_i;
        tool_pass_lamp_o <= norm_pass_lamp_i;
        tool_fail_lamp_o <= norm_fail_lamp_i;
        valve_o          <= norm_valve_i;
      end
    end
  end

endmodule

// >>> test/jss_chk.sv
/* port checker for the job select block.
   assumes bind to the design top, one clock, sync reset high. */
module jss_chk (
  input wire        clk_i,
  input wire        rst_i,
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_we_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o,
  input wire        wb_err_o,
  input wire [4:0]  term_in_n_i,
  input wire        span_stim_o,
  input wire [3:0]  job_number_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_hole; s_req ##0 (!wb_we_i && wb_adr_i == 32'h40); endsequence
  property p_ack_req; s_req |=> wb_ack_o; endproperty
  a_ack_req: assert property (p_ack_req) else $error("no ack");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_cause; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_hole; s_hole |=> wb_dat_o == 32'h0; endproperty
  a_hole: assert property (p_hole) else $error("unmapped read not zero");
  property p_err; wb_err_o == 1'b0; endproperty
  a_err: assert property (p_err) else $error("err raised");
  property p_job; job_number_o >= 4'h1 && job_number_o <= 4'h8; endproperty
  a_job: assert property (p_job) else $error("job out of range");
  property p_stim; span_stim_o |=> !span_stim_o; endproperty
  a_stim: assert property (p_stim) else $error("stimulus too long");
  property p_deb; $changed(term_in_n_i) |=> $stable(job_number_o)[*8]; endproperty
  a_deb: assert property (p_deb) else $error("job follows raw input");
endmodule

bind jss_job_select_and_self_check jss_chk jss_chk_i (.clk_i(clk_i), .rst_i(rst_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .term_in_n_i(term_in_n_i), .span_stim_o(span_stim_o), .job_number_o(job_number_o));

// >>> test/jss_far_side.sv
/* contacts to common and a torque sensor with a rated-load stimulus.
   assumes the stimulus adds the load to the sample in the cycle it is high. */
module jss_far_side (
  input  wire logic        clk_i,
  input  wire logic [4:0]  contact_i,
  input  wire logic        span_stim_i,
  input  wire logic [15:0] offset_i,
  input  wire logic [15:0] load_i,
  output logic      [4:0]  term_in_n_o,
  output logic      [15:0] sample_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] base_reg = 16'h0;
  assign term_in_n_o = ~contact_i;
  always @(posedge clk_i) base_reg <= offset_i;
  assign sample_o = span_stim_i ? base_reg + load_i : base_reg;
endmodule

// >>> test/test_job_select_and_self_check.sv
/* bench for the job select block: bus tasks and table driven checks.
   assumes the far side model for contacts and sensor. */
module test_job_select_and_self_check;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [31:0] wb_adr_i = 32'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic        wb_we_i = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic [3:0]  pol = 4'h5;
  logic [3:0]  ok = 4'hf;
  logic [4:0]  contact = 5'h0b;
  logic [15:0] offset = 16'h0;
  logic [15:0] load = 16'h3e8;
  logic [31:0] wb_dat_o, q, r;
  logic        wb_ack_o, pass_o, fail_o, valve_o, stim;
  logic [4:0]  term_in_n, term_out_o;
  logic [15:0] sample, torque_o;
  logic [3:0]  job_o;
  wire  [7:0]  outs = {valve_o, fail_o, pass_o, term_out_o};
  logic [39:0] st_tab [9];
  logic [39:0] rs_tab [6];
  int          err_count = 0;
  int          checked = 0;
  int          i, k;
  always #20 clk_i = ~clk_i;
  jss_far_side jss_far_side_i (.clk_i(clk_i), .contact_i(contact), .span_stim_i(stim),
    .offset_i(offset), .load_i(load), .term_in_n_o(term_in_n), .sample_o(sample));
  jss_job_select_and_self_check jss_job_select_and_self_check_i (.clk_i(clk_i),
    .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_sel_i(4'hf), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .wb_err_o(), .term_in_n_i(term_in_n), .polarity_switch_bank_i(pol),
    .prog_mem_ok_i(ok[0]), .work_mem_ok_i(ok[1]), .adc_ok_i(ok[2]),
    .settings_sum_ok_i(ok[3]), .sensor_sample_i(sample), .norm_out_i(5'h0a),
    .norm_pass_lamp_i(1'b1), .norm_fail_lamp_i(1'b0), .norm_valve_i(1'b1),
    .term_out_o(term_out_o), .tool_pass_lamp_o(pass_o), .tool_fail_lamp_o(fail_o),
    .valve_o(valve_o), .span_stim_o(stim), .torque_o(torque_o), .job_number_o(job_o));
  task automatic test_done;
    if (err_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {24'h0, a};
    wb_dat_i <= d;
    n = 0;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 100);
    if (wb_ack_o !== 1'b1) err_count++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic chk_job(input logic [3:0] e);
    for (int n = 0; n < 20 && job_o !== e; n++) @(posedge clk_i);
    chk(32'(job_o), 32'(e));
    wb(1'b0, 8'h0c, 32'h0, q);
    chk(q, 32'(e));
  endtask
  task automatic chk_port(input logic [15:0] e, input logic sel);
    for (int n = 0; n < 30000 && (sel ? torque_o : 16'(outs)) !== e; n++) @(posedge clk_i);
    chk(32'(sel ? torque_o : 16'(outs)), 32'(e));
  endtask
  initial begin
    repeat (90000) @(posedge clk_i);
    err_count++;
    test_done();
  end
  initial begin
    st_tab = '{40'hf000003e80, 40'ha000003e81, 40'h5000003e82, 40'hb000003e83,
               40'h7000003e84, 40'hf003d03e85, 40'hfffc403e80, 40'hf000003ab6, 40'hf000004256};
    rs_tab = '{40'h0400000000, 40'h1c000003e8, 40'h20000003e8, 40'h2400000064,
               40'h4000000000, 40'h0c00000001};
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, 8'h40, 32'hffff, q);
    for (i = 0; i < 6; i++) begin
      wb(1'b0, rs_tab[i][39:32], 32'h0, q);
      chk(q, rs_tab[i][31:0]);
    end
    for (i = 0; i < 9; i++) begin
      ok <= st_tab[i][39:36];
      offset <= st_tab[i][35:20];
      load <= st_tab[i][19:4];
      wb(1'b1, 8'h00, 32'h2, q);
      k = 0;
      do wb(1'b0, 8'h08, 32'h0, q); while ((q[7] || !q[6]) && ++k < 50);
      r = 32'h40 | st_tab[i][2:0] | (st_tab[i][3:0] == 4'h0 ? 32'h20 : 32'h0);
      chk(q & 32'h67, r);
    end
    wb(1'b1, 8'h20, 32'h1f4, q);
    wb(1'b1, 8'h24, 32'hc8, q);
    wb(1'b0, 8'h18, 32'h0, q);
    chk(q, 32'h3e8);
    offset <= 16'hffe7;
    wb(1'b1, 8'h00, 32'h8, q);
    k = 0;
    do wb(1'b0, 8'h08, 32'h0, q); while (q[7] && ++k < 50);
    wb(1'b0, 8'h14, 32'h0, q);
    chk(q, 32'h19);
    offset <= 16'hfff1;
    chk_port(16'h000a, 1'b1);
    pol <= 4'ha;
    chk_port(16'hfff6, 1'b1);
    wb(1'b0, 8'h08, 32'h0, q);
    chk(q & 32'h10, 32'h10);
    pol <= 4'h5;
    for (i = 0; i < 8; i++) begin
      r = 32'h7e00;
      for (k = 0; k < 3; k++) r[3*k+:3] = i[k] ? 3'd0 : 3'd2;
      wb(1'b1, 8'h04, r, q);
      if (i == 1) for (k = 0; k < 30000 && job_o !== 4'h2; k++) @(posedge clk_i);
      chk_job(4'(i + 1));
    end
    wb(1'b1, 8'h00, 32'h1, q);
    for (i = 0; i < 5; i++) begin
      r = 32'h7fff;
      r[3*i+:3] = 3'd0;
      wb(1'b1, 8'h04, r, q);
      chk_job(4'(i + 1));
    end
    wb(1'b1, 8'h04, 32'h731a, q);
    chk_job(4'h2);
    chk_port(16'haa, 1'b0);
    wb(1'b1, 8'h00, 32'h4, q);
    wb(1'b0, 8'h28, 32'h0, q);
    chk(q & 32'h1f, 32'h0b);
    wb(1'b1, 8'h10, 32'hff, q);
    chk_port(16'hff, 1'b0);
    wb(1'b1, 8'h10, 32'h25, q);
    chk_port(16'hda, 1'b0);
    wb(1'b1, 8'h00, 32'h0, q);
    chk_port(16'haa, 1'b0);
    wb(1'b1, 8'h04, 32'h7ffc, q);
    chk_job(4'h1);
    contact <= 5'h1b;
    repeat (1000) @(posedge clk_i);
    chk(32'(job_o), 32'h1);
    for (k = 0; k < 30000 && job_o !== 4'h2; k++) @(posedge clk_i);
    chk_job(4'h2);
    test_done();
  end
endmodule
